// ==== hw/spi_edge_watch.sv ====
`timescale 1ns/10ps
module spi_edge_watch (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched level and the idle flag that masks its edges
  input wire logic level_i,
  input wire logic idle_i,
  // edges
  output logic rise_o,
  output logic fall_o
);
  logic prev_ff;

  // follows level_i even while idle so enabling makes no false edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= level_i;
    end
  end

  assign rise_o = level_i && !prev_ff && !idle_i;
  assign fall_o = !level_i && prev_ff && !idle_i;
endmodule // spi_edge_watch

// ==== hw/spi_master_slave_port.sv ====
// Functional notes
// R1: software enables the port, and disables it around any reconfiguration
// R2: software sets pin directions; data input direction is automatic
// R3: a direction bit opposite to the serial need overrides that pin
// R4: shift out on programmed edge, latch on the opposite edge
// R5: master starts an eight bit transfer on buffer write
// R6: master with data output as input keeps receiving bytes normally
// R7: bytes go most significant bit first
// R8: master rate is clock/4, /16, /64 or half the timer rate
// R9: with edge select set, output is valid before the first edge
// R10: slave shifts on external clock, flags done after eighth bit
// R11: slave shift register keeps running while the device sleeps
// R12: slave byte done in sleep sets flag and wakes if enabled
// R13: select-controlled slave works and drives output only with select low
// R14: select high releases the data output at once, even mid byte; the code releases it one clock later through sdo_oe_ff
// R15: select high or port disable forces the bit counter to zero
// R16: software picks select-controlled slave when edge select is set
// R17: software keeps the select pin undriven and its latch high
// R18: data output as input disables transmission, allowing receive only
// R19: master transfer freezes during sleep and resumes after wake
// R20: device reset disables the port and aborts any transfer
// R21: standard modes map onto polarity and edge select bits
// R22: control and status reset to zero
// R23: mode field codes select master rates and slave variants
// R24: polarity sets idle level; edge select picks the transmit edge
// R25: sample bit moves master sampling to the end of output time
// R26: busy buffer write sets collision; full flag clears on read
// R27: timer pulse input toggles the serial clock in timer mode
`timescale 1ns/10ps
`include "spi_port_params.svh"
module spi_master_slave_port (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic NRST_I,
  // register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // system
  input wire logic SLEEP_I,
  input wire logic TIMER_PULSE_I,
  output logic WAKE_O,
  // serial pins
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  input wire logic SEL_N_I
);
  import spi_port_pkg::*;

  spi_port_pkg::ctrl_type ctrl_ff;
  spi_port_pkg::phase_type phase_ff;
  spi_port_pkg::mstate_type mst_ff;
  logic [7:0] buf_ff, tx_ff, rx_ff, dir_c_ff, dir_f_ff;
  logic [7:0] irq_flags_ff, irq_en_ff, irq_prio_ff, core_irq_ff;
  logic [7:0] rdata_ff;
  logic bf_ff, sck_ff, sck_oe_ff, sdo_oe_ff, wake_ff;
  logic [4:0] edge_ff;
  logic [2:0] cnt_ff;
  logic is_master, is_slave, sel_on, slave_act, busy;
  logic wr_buf, write_collision_flag_ev, load, m_start, tick;
  logic [4:0] base, last;
  logic m_sample, m_shift, m_done;
  logic sck_in, s_rise, s_fall, s_lead, s_trail, s_sample, s_shift;
  logic s_done, done_ev, ovf_ev;
  logic sel_n;

  // mode decode; reserved codes leave the port inert
  assign is_master = ctrl_ff.en && ctrl_ff.mode <= `MODE_TIMER; // see R23
  assign is_slave = ctrl_ff.en && (ctrl_ff.mode == `MODE_SLV_SEL ||
                                   ctrl_ff.mode == `MODE_SLV_FREE);
  // pins whose direction bit disagrees lose their serial role
  assign sel_n = dir_f_ff[`BIT_DIR_SEL] ? SEL_N_I : 1'b1; // see R3
  assign sck_in = dir_c_ff[`BIT_DIR_SCK] ? SCK_I : ctrl_ff.cpol; // see R3
  assign sel_on = ctrl_ff.mode == `MODE_SLV_FREE || !sel_n; // see R13
  assign slave_act = is_slave && sel_on;
  assign busy = mst_ff == M_RUN || (is_slave && cnt_ff != 3'h0);

  // buffer writes
  assign wr_buf = WR_I && ADDR_I == `REG_BUF;
  assign write_collision_flag_ev = wr_buf && busy; // see R26
  assign load = wr_buf && !busy;
  assign m_start = load && is_master; // see R5

  // master engine: edge_ff counts serial clock half periods
  spi_rate_gen u_rate (
    .clk_i(MCLK_I),
    .rst_n_i(NRST_I),
    .run_i(mst_ff == M_RUN && !SLEEP_I), // see R19
    .sel_i(ctrl_ff.mode[1:0]), // see R8
    .timer_pulse_i(TIMER_PULSE_I),
    .tick_o(tick)
  );

  // first sample edge: leading with edge select set, trailing otherwise,
  // pushed one half period later by the sample bit
  assign base = 5'({4'h0, !phase_ff.cke}) + 5'({4'h0, phase_ff.input_sample_phase_bit});
  assign last = (base == 5'd0) ? 5'd15 : base + 5'd14; // keep 16th edge
  assign m_sample = tick && edge_ff >= base && edge_ff[0] == base[0];
  assign m_shift = tick && edge_ff[0] == phase_ff.cke && edge_ff != 5'd0 &&
                   edge_ff < 5'd15; // see R24
  assign m_done = tick && edge_ff == last;

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mst_ff <= M_IDLE; // see R20
      edge_ff <= 5'd0;
    end else if (!is_master) begin
      mst_ff <= M_IDLE;
      edge_ff <= 5'd0;
    end else begin
      unique case (mst_ff)
        M_IDLE: begin
          edge_ff <= 5'd0;
          if (m_start) begin
            mst_ff <= M_RUN;
          end
        end
        M_RUN: begin
          if (m_done) begin
            mst_ff <= M_IDLE;
            edge_ff <= 5'd0;
          end else if (tick) begin
            edge_ff <= edge_ff + 5'd1;
          end
        end
      endcase
    end
  end

  // serial clock idles at the polarity level
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sck_ff <= 1'b0;
    end else if (mst_ff != M_RUN) begin
      sck_ff <= ctrl_ff.cpol; // see R24
    end else if (tick && edge_ff < 5'(`EDGES_PER_BYTE)) begin
      sck_ff <= !sck_ff;
    end
  end

  // slave engine on the external clock
  spi_edge_watch u_sck_edge (
    .clk_i(MCLK_I),
    .rst_n_i(NRST_I),
    .level_i(sck_in),
    .idle_i(!slave_act),
    .rise_o(s_rise),
    .fall_o(s_fall)
  );

  assign s_lead = ctrl_ff.cpol ? s_fall : s_rise;
  assign s_trail = ctrl_ff.cpol ? s_rise : s_fall;
  assign s_sample = phase_ff.cke ? s_lead : s_trail; // see R4 R21
  assign s_shift = (phase_ff.cke ? s_trail : s_lead) && cnt_ff != 3'h0;
  assign s_done = s_sample && cnt_ff == 3'h7; // see R10

  // edges keep counting whatever SLEEP_I says
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_ff <= 3'h0;
    end else if (!slave_act) begin
      cnt_ff <= 3'h0; // see R15
    end else if (s_sample) begin
      cnt_ff <= cnt_ff + 3'h1; // see R11
    end
  end

  // receive shifter, shared by both roles
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx_ff <= 8'h00;
    end else if (m_sample || (slave_act && s_sample)) begin
      rx_ff <= {rx_ff[6:0], SDI_I}; // see R7
    end
  end

  // transmit shifter: bit 7 is on the pin from load onward
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx_ff <= 8'h00;
    end else if (load) begin
      tx_ff <= WDATA_I; // see R9
    end else if (m_shift || (slave_act && s_shift)) begin
      tx_ff <= {tx_ff[6:0], 1'b0}; // see R7
    end
  end

  assign done_ev = m_done || (slave_act && s_done); // see R6
  // a slave byte ending over an unread buffer is lost; master never overflows
  assign ovf_ev = slave_act && s_done && bf_ff;

  // buffer and full flag; the set beats a same-cycle read
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      buf_ff <= `RST_BUF;
      bf_ff <= 1'b0; // see R22
    end else begin
      if (done_ev && !ovf_ev) begin
        buf_ff <= (m_done && !m_sample) ? rx_ff : {rx_ff[6:0], SDI_I};
      end else if (load) begin
        buf_ff <= WDATA_I;
      end
      if (done_ev && !ovf_ev) begin
        bf_ff <= 1'b1;
      end else if (RD_I && ADDR_I == `REG_BUF) begin
        bf_ff <= 1'b0; // see R26
      end
    end
  end

  // control register; collision and overflow are set-wins sticky
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_ff <= `RST_CTRL; // see R22
    end else begin
      if (WR_I && ADDR_I == `REG_CTRL) begin
        ctrl_ff <= WDATA_I; // see R1
      end
      if (write_collision_flag_ev) begin
        ctrl_ff.write_collision_flag <= 1'b1;
      end
      if (ovf_ev) begin
        ctrl_ff.ovf <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      phase_ff <= 2'h0;
    end else if (WR_I && ADDR_I == `REG_STATE) begin
      phase_ff <= WDATA_I[7:6]; // see R25
    end
  end

  // direction and interrupt side registers
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      dir_c_ff <= `RST_DIR;
      dir_f_ff <= `RST_DIR;
      irq_en_ff <= `RST_IRQ;
      irq_prio_ff <= `RST_PRIO;
      core_irq_ff <= `RST_IRQ;
    end else if (WR_I) begin
      if (ADDR_I == `REG_DIR_C) begin
        dir_c_ff <= WDATA_I;
      end
      if (ADDR_I == `REG_DIR_F) begin
        dir_f_ff <= WDATA_I;
      end
      if (ADDR_I == `REG_IRQ_EN) begin
        irq_en_ff <= WDATA_I;
      end
      if (ADDR_I == `REG_IRQ_PRIO) begin
        irq_prio_ff <= WDATA_I;
      end
      if (ADDR_I == `REG_CORE_IRQ) begin
        core_irq_ff <= WDATA_I;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_flags_ff <= `RST_IRQ;
    end else begin
      if (WR_I && ADDR_I == `REG_IRQ_FLAGS) begin
        irq_flags_ff <= WDATA_I;
      end
      if (done_ev) begin
        irq_flags_ff[`BIT_DONE] <= 1'b1; // see R10
      end
    end
  end

  // wake request only matters while asleep
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= SLEEP_I && irq_flags_ff[`BIT_DONE] &&
                 irq_en_ff[`BIT_DONE]; // see R12
    end
  end

  // pin enables; registered, so release lags select by one clock
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sck_oe_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      sck_oe_ff <= is_master && !dir_c_ff[`BIT_DIR_SCK]; // see R3
      sdo_oe_ff <= !dir_c_ff[`BIT_DIR_SDO] &&
                   (is_master || slave_act); // see R14 R18
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_ff <= 8'h00;
    end else if (RD_I) begin
      unique case (ADDR_I)
        `REG_CTRL: rdata_ff <= ctrl_ff;
        `REG_STATE: rdata_ff <= {phase_ff, 5'h00, bf_ff};
        `REG_BUF: rdata_ff <= buf_ff;
        `REG_DIR_C: rdata_ff <= dir_c_ff;
        `REG_DIR_F: rdata_ff <= dir_f_ff;
        `REG_IRQ_FLAGS: rdata_ff <= irq_flags_ff;
        `REG_IRQ_EN: rdata_ff <= irq_en_ff;
        `REG_IRQ_PRIO: rdata_ff <= irq_prio_ff;
        `REG_CORE_IRQ: rdata_ff <= core_irq_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign RDATA_O = rdata_ff;
  assign WAKE_O = wake_ff;
  assign SCK_O = sck_ff;
  assign SCK_OE_O = sck_oe_ff;
  assign SDO_O = tx_ff[7];
  assign SDO_OE_O = sdo_oe_ff;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  AST_BF_ON_DONE: assert property ( // see R26
    (done_ev && !ovf_ev) |=> bf_ff && buf_ff == rx_ff)
    else $error("full flag or buffer not updated at byte end");
  AST_WRITE_COLLISION_FLAG_ON_BUSY: assert property ( // see R26
    write_collision_flag_ev |=> ctrl_ff.write_collision_flag && tx_ff == ($past(m_shift ||
      (slave_act && s_shift)) ? {$past(tx_ff[6:0]), 1'b0} : $past(tx_ff)))
    else $error("busy write did not flag collision");
  AST_SDO_RELEASE: assert property ( // see R14
    (is_slave && ctrl_ff.mode == `MODE_SLV_SEL && sel_n) |=> !SDO_OE_O)
    else $error("data output still driven with select high");
  AST_CNT_CLEAR: assert property ( // see R15
    !slave_act |=> cnt_ff == 3'h0)
    else $error("bit counter not cleared");
  AST_MASTER_START: assert property ( // see R5
    m_start |=> mst_ff == M_RUN && SDO_O == $past(WDATA_I[7]))
    else $error("master did not start on buffer write");
  AST_SLEEP_FREEZE: assert property ( // see R19
    (mst_ff == M_RUN && SLEEP_I && is_master) |=> $stable(edge_ff)
      && $stable(sck_ff))
    else $error("master transfer moved during sleep");
  AST_SCK_IDLE: assert property ( // see R24
    (mst_ff == M_IDLE && $past(mst_ff == M_IDLE) && $stable(ctrl_ff.cpol))
      |-> SCK_O == ctrl_ff.cpol)
    else $error("serial clock not at idle level");
  AST_DONE_FLAG: assert property ( // see R12
    done_ev |=> irq_flags_ff[`BIT_DONE] ##1
      (wake_ff == ($past(SLEEP_I) && $past(irq_en_ff[`BIT_DONE]))))
    else $error("done flag or wake not raised");
  AST_MASTER_LEN: assert property ( // see R8
    (m_start && ctrl_ff.mode == `MODE_DIV4 && !SLEEP_I) ##1
      (!SLEEP_I && is_master) [*8] |-> mst_ff == M_RUN)
    else $error("master byte ended too early");
endmodule // spi_master_slave_port

// ==== hw/spi_port_params.svh ====
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// register indices on the plain register port
`define REG_CTRL 4'h0
`define REG_STATE 4'h1
`define REG_BUF 4'h2
`define REG_DIR_C 4'h3
`define REG_DIR_F 4'h4
`define REG_IRQ_FLAGS 4'h5
`define REG_IRQ_EN 4'h6
`define REG_IRQ_PRIO 4'h7
`define REG_CORE_IRQ 4'h8

// reset values
`define RST_CTRL 8'h00
`define RST_STATE 8'h00
`define RST_BUF 8'h00
`define RST_DIR 8'hff
`define RST_IRQ 8'h00
`define RST_PRIO 8'h7f

// field positions
`define BIT_DONE 3
`define BIT_DIR_SCK 3
`define BIT_DIR_SDO 5
`define BIT_DIR_SEL 7

// mode field codes
`define MODE_DIV4 4'h0
`define MODE_DIV16 4'h1
`define MODE_DIV64 4'h2
`define MODE_TIMER 4'h3
`define MODE_SLV_SEL 4'h4
`define MODE_SLV_FREE 4'h5

// system clock cycles per serial clock period, halved per toggle
`define SCK_DIV4 4
`define SCK_DIV16 16
`define SCK_DIV64 64
`define HALF_DIV4 (`SCK_DIV4 / 2)
`define HALF_DIV16 (`SCK_DIV16 / 2)
`define HALF_DIV64 (`SCK_DIV64 / 2)

// bit times per byte, counted in serial clock edges
`define EDGES_PER_BYTE 16
`endif

// ==== hw/spi_port_pkg.sv ====
package spi_port_pkg;
  typedef struct packed {
    logic write_collision_flag;
    logic ovf;
    logic en;
    logic cpol;
    logic [3:0] mode;
  } ctrl_type;

  typedef struct packed {
    logic input_sample_phase_bit;
    logic cke;
  } phase_type;

  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_RUN = 1'b1
  } mstate_type;
endpackage

// ==== hw/spi_rate_gen.sv ====
`timescale 1ns/10ps
`include "spi_port_params.svh"
module spi_rate_gen (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  input wire logic timer_pulse_i,
  // half period strobe
  output logic tick_o
);
  logic [7:0] cnt_ff;
  logic [7:0] limit;

  always_comb begin
    unique case (sel_i)
      2'h0: limit = 8'(`HALF_DIV4 - 1);
      2'h1: limit = 8'(`HALF_DIV16 - 1);
      2'h2: limit = 8'(`HALF_DIV64 - 1);
      2'h3: limit = 8'h00;
    endcase
  end

  // counter restarts with every byte so the first half period is full
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 8'h00;
    end else if (!run_i || cnt_ff == limit) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  always_comb begin
    if (sel_i == 2'h3) begin
      tick_o = run_i && timer_pulse_i; // see R27
    end else begin
      tick_o = run_i && cnt_ff == limit;
    end
  end
endmodule // spi_rate_gen

// ==== verification/spi_peer_model.sv ====
`timescale 1ns/10ps
module spi_peer_model (
  // wire levels seen by the peer
  input wire logic sck_i,
  input wire logic dout_i,
  // link settings and byte to send
  input wire logic cpol_i,
  input wire logic cke_i,
  input wire logic arm_i,
  input wire logic [7:0] tx_i,
  // lines the peer drives
  output logic din_o,
  output logic sck_o,
  output logic sel_n_o,
  output logic [7:0] rx_o
);
  logic [2:0] idx;
  logic first;
  initial begin
    sck_o = 1'h0;
    sel_n_o = 1'h1;
  end
  // unarmed, the data line floats up to the pull-up level
  assign din_o = arm_i ? tx_i[3'h7 - idx] : 1'h1;
  always @(posedge arm_i) begin
    idx = 3'h0;
    first = 1'h1;
    rx_o = 8'h00;
  end
  always @(cpol_i) begin
    if (sel_n_o) begin
      sck_o = cpol_i;
    end
  end
  // leading edge samples when cke is set, the trailing one otherwise
  always @(sck_i) begin
    if (arm_i) begin
      if ((sck_i != cpol_i) == cke_i) begin
        rx_o = {rx_o[6:0], dout_i};
      end else if (first && !cke_i) begin
        first = 1'h0;
      end else if (idx != 3'h7) begin
        idx = idx + 3'h1;
      end
    end
  end
  // link master role: select low, then the requested number of edges
  task automatic run_master(input int edges);
    // step off the system clock edge so the device samples settled levels
    #2;
    sck_o = cpol_i;
    sel_n_o = 1'h0;
    #100;
    repeat (edges) begin
      sck_o = ~sck_o;
      #100;
    end
    sel_n_o = 1'h1;
    sck_o = cpol_i;
  endtask
endmodule // spi_peer_model

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`include "spi_port_params.svh"
module tb;
  typedef struct packed {
    logic [3:0] m;
    logic cp, ck, sp;
    logic [7:0] dc, dt, pt, ep;
    logic [5:0] hf;
  } row_type;
  logic clk = 1'h0, nrst = 1'h0, wr_s = 1'h0, rd_s = 1'h0;
  logic sleep = 1'h0, tpulse = 1'h0, meas = 1'h0;
  logic p_cp = 1'h0, p_ck = 1'h0, p_arm = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, p_tx = 8'h00, rdata, p_rx;
  logic wake, sck_o, sck_oe, dout, dout_oe, p_sck, p_din, p_sel_n, sck_q;
  wire sck_w = sck_oe ? sck_o : p_sck;
  wire dout_w = dout_oe ? dout : 1'h1;
  int mismatches = 0, n_checks = 0, toggles = 0, gap = 0, bad_gap = 0;
  int half = 0, tcnt = 0;
  // mode 0,0 / 0,1 / 1,0 / 1,1, late sample, receive only, two slaves
  row_type rows [8] = '{
    '{`MODE_DIV4, 1'h0, 1'h1, 1'h0, 8'hd7, 8'ha5, 8'h3c, 8'ha5, 6'h02},
    '{`MODE_DIV16, 1'h0, 1'h0, 1'h0, 8'hd7, 8'h81, 8'h7e, 8'h81, 6'h08},
    '{`MODE_DIV64, 1'h1, 1'h1, 1'h0, 8'hd7, 8'h5a, 8'hc3, 8'h5a, 6'h20},
    '{`MODE_TIMER, 1'h1, 1'h0, 1'h0, 8'hd7, 8'he1, 8'h18, 8'he1, 6'h03},
    '{`MODE_DIV4, 1'h0, 1'h1, 1'h1, 8'hd7, 8'h96, 8'h69, 8'h96, 6'h02},
    '{`MODE_DIV16, 1'h0, 1'h1, 1'h0, 8'hf7, 8'h33, 8'hcc, 8'hff, 6'h08},
    '{`MODE_SLV_SEL, 1'h0, 1'h1, 1'h0, 8'hdf, 8'h4b, 8'hb4, 8'h4b, 6'h00},
    '{`MODE_SLV_FREE, 1'h1, 1'h0, 1'h0, 8'hdf, 8'h2d, 8'hd2, 8'h2d, 6'h00}
  };
  spi_master_slave_port dut_u (
    .MCLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .SLEEP_I(sleep),
    .TIMER_PULSE_I(tpulse), .WAKE_O(wake), .SCK_I(sck_w), .SCK_O(sck_o),
    .SCK_OE_O(sck_oe), .SDI_I(p_din), .SDO_O(dout), .SDO_OE_O(dout_oe),
    .SEL_N_I(p_sel_n));
  spi_peer_model peer_u (.sck_i(sck_w), .dout_i(dout_w), .cpol_i(p_cp),
    .cke_i(p_ck), .arm_i(p_arm), .tx_i(p_tx), .din_o(p_din),
    .sck_o(p_sck), .sel_n_o(p_sel_n), .rx_o(p_rx));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tcnt <= (tcnt == 2) ? 0 : tcnt + 1;
    tpulse <= (tcnt == 2);
  end
  // toggles of the clock output and the spacing between them
  always @(posedge clk) begin
    sck_q <= sck_o;
    gap <= gap + 1;
    if (!meas) begin
      toggles <= 0;
    end else if (sck_o !== sck_q) begin
      if (toggles > 0 && half != 0 && gap != half) bad_gap <= bad_gap + 1;
      toggles <= toggles + 1;
      gap <= 1;
    end
  end
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clk);
    rd_s <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic chk_regs();
    logic [7:0] v;
    logic [7:0] rv [10];
    rv = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h7f, 8'h00,
      8'h00};
    for (int i = 0; i < 10; i++) begin
      rd(i[3:0], v);
      if (i != 2) chk("reg_reset", v, rv[i]);
    end
  endtask
  task automatic wait_done();
    logic [7:0] f;
    for (int i = 0; i < 300; i++) begin
      rd(`REG_IRQ_FLAGS, f);
      if (f[`BIT_DONE] === 1'h1) begin
        wr(`REG_IRQ_FLAGS, 8'h00);
        return;
      end
    end
    mismatches++;
    $display("mismatch done_flag expected 1 seen 0");
    close_out();
  endtask
  task automatic arm();
    p_arm <= 1'h0;
    @(posedge clk);
    p_arm <= 1'h1;
  endtask
  task automatic cfg(input row_type r);
    wr(`REG_CTRL, {3'h0, r.cp, r.m});
    p_cp <= r.cp;
    p_ck <= r.ck;
    p_tx <= r.pt;
    wr(`REG_DIR_C, r.dc);
    wr(`REG_DIR_F, 8'hff);
    wr(`REG_STATE, {r.sp, r.ck, 6'h00});
    wr(`REG_CTRL, {3'h1, r.cp, r.m});
    arm();
    repeat (2) @(posedge clk);
  endtask
  // kind: 0 plain, 1 sleep mid byte, 2 collision, 3 slave asleep, 4 abort
  task automatic xfer(input row_type r, input int kind);
    logic [7:0] v;
    logic mst, oe;
    mst = (r.m <= `MODE_TIMER);
    oe = !r.dc[5] && (mst || r.m == `MODE_SLV_FREE);
    cfg(r);
    half = (kind == 1) ? 0 : r.hf;
    meas <= 1'h1;
    wr(`REG_BUF, r.dt);
    if (kind == 2) wr(`REG_BUF, ~r.dt);
    if (kind == 4) begin
      peer_u.run_master(7);
      repeat (2) @(posedge clk);
      chk("dout_release", dout_oe, 1'h0);
      arm();
      wr(`REG_BUF, r.dt);
    end
    if (kind == 3) begin
      wr(`REG_IRQ_EN, 8'h08);
      sleep <= 1'h1;
    end
    if (kind == 1) begin
      repeat (30) @(posedge clk);
      sleep <= 1'h1;
      repeat (2) @(posedge clk);
      v = toggles[7:0];
      repeat (40) @(posedge clk);
      chk("frozen", toggles[7:0], v);
      sleep <= 1'h0;
    end
    if (!mst) peer_u.run_master(16);
    if (kind == 3) begin
      repeat (4) @(posedge clk);
      chk("wake", wake, 1'h1);
      sleep <= 1'h0;
      wr(`REG_IRQ_EN, 8'h00);
    end
    wait_done();
    rd(`REG_STATE, v);
    chk("buf_full", v[0], 1'h1);
    rd(`REG_BUF, v);
    chk("rx_byte", v, r.pt);
    rd(`REG_STATE, v);
    chk("buf_empty", v[0], 1'h0);
    rd(`REG_CTRL, v);
    chk("collision", v[7], kind == 2);
    chk("peer_rx", p_rx, r.ep);
    chk("edges", toggles[7:0], mst ? 8'h10 : 8'h00);
    chk("sck_idle", sck_o, r.cp);
    chk("sck_dir", sck_oe, mst);
    chk("dout_dir", dout_oe, oe);
    meas <= 1'h0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    chk_regs();
    for (int i = 0; i < 8; i++) begin
      xfer(rows[i], 0);
    end
    xfer(rows[1], 1);
    xfer(rows[2], 2);
    xfer(rows[6], 3);
    xfer(rows[6], 4);
    cfg(rows[0]);
    wr(`REG_BUF, 8'h55);
    repeat (9) @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("reset_sck_dir", sck_oe, 1'h0);
    chk("reset_sck", sck_o, 1'h0);
    chk("reset_dout_dir", dout_oe, 1'h0);
    nrst <= 1'h1;
    chk_regs();
    chk("sck_rate", bad_gap[7:0], 8'h00);
    close_out();
  end
endmodule // tb
